// *** src/eisc_defines.svh ***
// Constants for the external interrupt sense control block.
// Assumes one 100 MHz system clock and a plain register port.
`ifndef EISC_DEFINES_SVH
`define EISC_DEFINES_SVH

`define EISC_ADDR_W          4
`define EISC_DATA_W          16
`define EISC_OFS_DETECT      4'h0
`define EISC_OFS_EDGE_DIR    4'h1
`define EISC_OFS_FLAGS       4'h2
`define EISC_OFS_PRIO        4'h3
`define EISC_OFS_NMI_FLAG    4'h4
`define EISC_BIT_NMI_LEVEL   15
`define EISC_BIT_NMI_EDGE    8
`define EISC_BIT_SENSE_HI    7
`define EISC_BIT_SENSE_LO    4
`define EISC_DETECT_WMASK    16'h01f0
`define EISC_EDGE_WMASK      16'hff00
`define EISC_FLAG_WMASK      16'h00f0
`define EISC_FLAG_LO         4
`define EISC_EDGE_FALL       2'h0
`define EISC_EDGE_RISE       2'h1
`define EISC_EDGE_BOTH       2'h2
`define EISC_NMI_FILT_NS     20
`define EISC_CLK_PERIOD_NS   10
`define EISC_NMI_FILT_CYC    ((`EISC_NMI_FILT_NS + `EISC_CLK_PERIOD_NS - 1) / `EISC_CLK_PERIOD_NS)

`endif

// *** src/eisc_pkg.sv ***
// Types shared by the external interrupt sense control block.
// Assumes eisc_defines.svh is included before this package is used.
`include "eisc_defines.svh"
package eisc_pkg;
    typedef struct packed {
        logic [`EISC_ADDR_W-1:0] addr;
        logic [`EISC_DATA_W-1:0] wdata;
        logic                    wr;
        logic                    rd;
    } eisc_bus_s;

    typedef logic [3:0] eisc_prio_t;

    typedef enum logic [2:0] {
        EISC_IDLE    = 3'b001,
        EISC_PRESENT = 3'b010,
        EISC_ACK     = 3'b100
    } eisc_notify_e;
endpackage

// *** src/eisc_top.sv ***
// External interrupt sense control: NMI and four request pins to the CPU.
// Assumes pins are asynchronous inputs and a plain single-cycle register port.
//
// Behaviour
// - Rank sources over fifteen priority levels.
// - Filter short glitches on the NMI pin.
// - Drive notify pin when a request occurs.
// - Request pins maskable, NMI pin non-maskable.
// - Detection register is sixteen bits wide.
// - Bit 15 reads filtered NMI level, read-only.
// - Reserved detection bits read back as zero.
// - Bit 8 picks NMI falling or rising edge.
// - Bits 7..4 pick level or edge per pin.
// - Level mode requests while pin is low.
// - Edge mode uses per-pin direction field.
// - Direction 00 fall, 01 rise, 10 both.
// - Level mode ignores the direction field.
// - Edge flag clears by write 0 after read 1.
`timescale 1ns/1ps
`include "eisc_defines.svh"

module eisc_top #(
    parameter int NMI_FILT_CYC = `EISC_NMI_FILT_CYC
) (
    input  wire logic                    clk_sys_in,
    input  wire logic                    sys_rst_in,
    input  wire logic                    nmi_in,
    input  wire logic [3:0]              req_pin_n_in,
    input  wire logic [`EISC_ADDR_W-1:0] reg_addr_in,
    input  wire logic [`EISC_DATA_W-1:0] reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    input  wire logic                    cpu_ack_in,
    output logic      [`EISC_DATA_W-1:0] reg_rdata_out,
    output logic                         cpu_req_out,
    output logic                         cpu_nmi_out,
    output logic      [3:0]              cpu_level_out,
    output logic      [2:0]              cpu_src_out,
    output logic                         interrupt_notify_n_out
);

    // ******************************************************************
    // Synchronisers and NMI filter
    // ******************************************************************
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    logic       nmi_filt;
    logic [7:0] filt_cnt;

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1 <= 5'h1f;
            sync2 <= 5'h1f;
        end else begin
            sync1 <= {nmi_in, req_pin_n_in};
            sync2 <= sync1;
        end
    end

    // The filtered NMI level follows the pin only after it has held steady.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            nmi_filt <= 1'b1;
            filt_cnt <= 8'h00;
        end else if (sync2[4] == nmi_filt) begin
            filt_cnt <= 8'h00;
        end else if (filt_cnt >= 8'(NMI_FILT_CYC - 1)) begin
            nmi_filt <= sync2[4];
            filt_cnt <= 8'h00;
        end else begin
            filt_cnt <= filt_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prev <= 5'h1f;
        end else begin
            prev <= {nmi_filt, sync2[3:0]};
        end
    end

    // ******************************************************************
    // Registers
    // ******************************************************************
    eisc_pkg::eisc_bus_s bus;
    assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    logic        nmi_edge_sel;
    logic [3:0]  sense_sel;
    logic [7:0]  edge_dir;
    logic [3:0]  req_pending_flag;
    logic [3:0]  flag_seen_one;
    logic        nmi_flag;
    logic [15:0] prio;

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            nmi_edge_sel <= 1'b0;
            sense_sel    <= 4'h0;
        end else if (bus.wr && bus.addr == `EISC_OFS_DETECT) begin
            // Reserved and level bits are not stored, so they cannot be altered.
            nmi_edge_sel <= bus.wdata[`EISC_BIT_NMI_EDGE];
            sense_sel    <= bus.wdata[`EISC_BIT_SENSE_HI:`EISC_BIT_SENSE_LO];
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            edge_dir <= 8'h00;
        end else if (bus.wr && bus.addr == `EISC_OFS_EDGE_DIR) begin
            edge_dir <= bus.wdata[15:8];
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prio <= 16'h0000;
        end else if (bus.wr && bus.addr == `EISC_OFS_PRIO) begin
            prio <= bus.wdata;
        end
    end

    // ******************************************************************
    // Detection
    // ******************************************************************
    // Pin n sits at bit 3-n of the sense field and bits 7-2n..6-2n of edge_dir.
    function automatic logic edge_hit(input logic [1:0] dir, input logic cur, input logic old);
        logic fall;
        logic rise;
        fall = old & ~cur;
        rise = ~old & cur;
        unique case (dir)
            `EISC_EDGE_FALL: edge_hit = fall;
            `EISC_EDGE_RISE: edge_hit = rise;
            `EISC_EDGE_BOTH: edge_hit = fall | rise;
            default:         edge_hit = 1'b0;
        endcase
    endfunction

    logic [3:0] edge_evt;
    logic [3:0] req_active;
    logic       nmi_evt;

    always_comb begin
        for (int n = 0; n < 4; n++) begin
            edge_evt[n] = edge_hit(edge_dir[7-2*n -: 2], sync2[n], prev[n]);
            req_active[n] = sense_sel[3-n] ? req_pending_flag[n]
                                           : ~sync2[n];
        end
    end

    assign nmi_evt = nmi_edge_sel ? (~prev[4] & nmi_filt) : (prev[4] & ~nmi_filt);

    // Flag sets win over a simultaneous clear; a 0 write clears only after a 1 was read.
    logic rd_flags;
    logic wr_flags;
    assign rd_flags = bus.rd && bus.addr == `EISC_OFS_FLAGS;
    assign wr_flags = bus.wr && bus.addr == `EISC_OFS_FLAGS;

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            req_pending_flag <= 4'h0;
            flag_seen_one    <= 4'h0;
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (sense_sel[3-n] && edge_evt[n]) begin
                    req_pending_flag[n] <= 1'b1;
                end else if (wr_flags && !bus.wdata[`EISC_FLAG_LO+3-n]
                             && flag_seen_one[n]) begin
                    req_pending_flag[n] <= 1'b0;
                end
                if (rd_flags && req_pending_flag[n]) begin
                    flag_seen_one[n] <= 1'b1;
                end else if (wr_flags || !req_pending_flag[n]) begin
                    flag_seen_one[n] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            nmi_flag <= 1'b0;
        end else if (nmi_evt) begin
            nmi_flag <= 1'b1;
        end else if (cpu_ack_in && cpu_nmi_out) begin
            nmi_flag <= 1'b0;
        end
    end

    // ******************************************************************
    // Priority ranking
    // ******************************************************************
    logic [3:0] best_lvl;
    logic [2:0] best_src;

    always_comb begin
        best_lvl = 4'h0;
        best_src = 3'h0;
        for (int n = 0; n < 4; n++) begin
            if (req_active[n] && prio[15-4*n -: 4] > best_lvl) begin
                best_lvl = prio[15-4*n -: 4];
                best_src = 3'(n);
            end
        end
    end

    // ******************************************************************
    // CPU request and notify pin
    // ******************************************************************
    eisc_pkg::eisc_notify_e state;

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state                  <= eisc_pkg::EISC_IDLE;
            cpu_req_out            <= 1'b0;
            cpu_nmi_out            <= 1'b0;
            cpu_level_out          <= 4'h0;
            cpu_src_out            <= 3'h0;
            interrupt_notify_n_out <= 1'b1;
        end else begin
            unique case (state)
                eisc_pkg::EISC_IDLE: begin
                    if (nmi_flag) begin
                        state                  <= eisc_pkg::EISC_PRESENT;
                        cpu_req_out            <= 1'b1;
                        cpu_nmi_out            <= 1'b1;
                        cpu_level_out          <= 4'hf;
                        cpu_src_out            <= 3'h4;
                        interrupt_notify_n_out <= 1'b0;
                    end else if (best_lvl != 4'h0) begin
                        state                  <= eisc_pkg::EISC_PRESENT;
                        cpu_req_out            <= 1'b1;
                        cpu_nmi_out            <= 1'b0;
                        cpu_level_out          <= best_lvl;
                        cpu_src_out            <= best_src;
                        interrupt_notify_n_out <= 1'b0;
                    end
                end
                eisc_pkg::EISC_PRESENT: begin
                    if (cpu_ack_in) begin
                        state                  <= eisc_pkg::EISC_ACK;
                        cpu_req_out            <= 1'b0;
                        cpu_nmi_out            <= 1'b0;
                        interrupt_notify_n_out <= 1'b1;
                    end
                end
                eisc_pkg::EISC_ACK: begin
                    // One idle cycle lets a level request be re-sampled.
                    state <= eisc_pkg::EISC_IDLE;
                end
                default: begin
                    state <= eisc_pkg::EISC_IDLE;
                end
            endcase
        end
    end

    // ******************************************************************
    // Read port
    // ******************************************************************
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `EISC_OFS_DETECT:   reg_rdata_out <= {nmi_filt, 6'h00, nmi_edge_sel,
                                                      sense_sel, 4'h0};
                `EISC_OFS_EDGE_DIR: reg_rdata_out <= {edge_dir, 8'h00};
                `EISC_OFS_FLAGS:    reg_rdata_out <= {8'h00, req_pending_flag[0],
                                                      req_pending_flag[1],
                                                      req_pending_flag[2],
                                                      req_pending_flag[3], 4'h0};
                `EISC_OFS_PRIO:     reg_rdata_out <= prio;
                `EISC_OFS_NMI_FLAG: reg_rdata_out <= {15'h0000, nmi_flag};
                default:            reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule // eisc_top

// *** sim/eisc_cpu_model.sv ***
// CPU side model: acknowledges each presented request, promptly or slowly.
// Assumes the request holds until it is acknowledged.
`timescale 1ns/1ps
module eisc_cpu_model (
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    input  wire logic       slow_in,
    input  wire logic       req_in,
    input  wire logic [2:0] src_in,
    input  wire logic [3:0] level_in,
    output logic            ack_out,
    output logic [7:0]      acks_out,
    output logic [6:0]      seen_out
);
    logic [2:0] wait_cnt;

    // Acks are one cycle long and are only given while a request stands.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ack_out  <= 1'b0;
            wait_cnt <= 3'h0;
            acks_out <= 8'h00;
            seen_out <= 7'h00;
        end else if (ack_out || !req_in) begin
            ack_out  <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (wait_cnt == (slow_in ? 3'h5 : 3'h0)) begin
            ack_out  <= 1'b1;
            acks_out <= acks_out + 8'h01;
            seen_out <= {src_in, level_in};
        end else begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule // eisc_cpu_model

// *** sim/eisc_top_sva.sv ***
// Port checker for eisc_top.
// Assumes one clock domain; the bind stands at the foot.
`timescale 1ns/1ps
module eisc_top_sva (
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic        reg_rd_in,
    input wire logic        cpu_ack_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        cpu_req_out,
    input wire logic        cpu_nmi_out,
    input wire logic [3:0]  cpu_level_out,
    input wire logic [2:0]  cpu_src_out,
    input wire logic        interrupt_notify_n_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    chk_rd_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data outside slot");
    chk_rsvd_zero: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 4'h0
        |-> reg_rdata_out[14:9] == 6'h00 && reg_rdata_out[3:0] == 4'h0)
        else $error("reserved bits set");
    chk_unmapped_zero: assert property ($past(reg_rd_in) && $past(reg_addr_in) > 4'h4
        |-> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    chk_notify_req: assert property (interrupt_notify_n_out == !cpu_req_out)
        else $error("notify pin disagrees");
    chk_req_hold: assert property (cpu_req_out && !cpu_ack_in |=> cpu_req_out
        && $stable(cpu_src_out) && $stable(cpu_level_out) && $stable(cpu_nmi_out))
        else $error("request changed before ack");
    chk_ack_drop: assert property (cpu_req_out && cpu_ack_in |=> !cpu_req_out)
        else $error("request kept after ack");
    chk_nmi_src: assert property (cpu_req_out && cpu_nmi_out
        |-> cpu_src_out == 3'h4 && cpu_level_out == 4'hf)
        else $error("nmi source or level wrong");
    chk_pin_level: assert property (cpu_req_out && !cpu_nmi_out
        |-> cpu_level_out != 4'h0 && cpu_src_out < 3'h4)
        else $error("masked or bad pin request");

    cover property (cpu_req_out && cpu_nmi_out);
    cover property (cpu_req_out && !cpu_nmi_out);
    cover property ($past(reg_rd_in) && reg_rdata_out[15]);
endmodule // eisc_top_sva

bind eisc_top eisc_top_sva eisc_top_sva_inst (.clk_sys_in, .sys_rst_in, .reg_addr_in,
    .reg_rd_in, .cpu_ack_in, .reg_rdata_out, .cpu_req_out, .cpu_nmi_out, .cpu_level_out,
    .cpu_src_out, .interrupt_notify_n_out);

// *** sim/external_interrupt_sense_control_test.sv ***
// Self-checking bench for the external interrupt sense control block.
// Assumes eisc_top, the CPU model and the bound checker.
`timescale 1ns/1ps
module external_interrupt_sense_control_test;
    logic        clk_sys_in, sys_rst_in, nmi_in, wr, rd, ack, req, nmi, notify_n, slow;
    logic [3:0]  pins, addr, lvl;
    logic [15:0] wdata, rdata;
    logic [2:0]  src;
    logic [7:0]  acks;
    logic [6:0]  seen;
    logic [35:0] rows [5];
    int          failures, n_tests;

    eisc_top eisc_top_inst (.clk_sys_in, .sys_rst_in, .nmi_in, .req_pin_n_in(pins),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .cpu_ack_in(ack), .reg_rdata_out(rdata), .cpu_req_out(req), .cpu_nmi_out(nmi),
        .cpu_level_out(lvl), .cpu_src_out(src), .interrupt_notify_n_out(notify_n));
    eisc_cpu_model eisc_cpu_model_inst (.clk_sys_in, .sys_rst_in, .slow_in(slow),
        .req_in(req), .src_in(src), .level_in(lvl), .ack_out(ack), .acks_out(acks),
        .seen_out(seen));

    task automatic test_done;
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic eq(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys_in);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys_in);
        rd   <= 1'b0;
        #1;
        eq(rdata, exp);
    endtask

    task automatic wait_ack;
        logic [7:0] n0;
        int         k;
        n0 = acks;
        k  = 0;
        while (acks === n0 && k < 100) begin
            @(negedge clk_sys_in);
            k++;
        end
        eq(16'(acks - n0), 16'h0001);
    endtask

    task automatic no_ack(input int c);
        logic [7:0] n0;
        n0 = acks;
        repeat (c) @(posedge clk_sys_in);
        #1;
        eq(16'(acks - n0), 16'h0000);
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        #100000;
        failures++;
        $display("MISMATCH %0t timeout", $time);
        test_done();
    end

    initial begin
        rows = '{{4'h0, 16'h01f0, 16'h81f0}, {4'h1, 16'h9900, 16'h9900},
                 {4'h3, 16'h1234, 16'h1234}, {4'h7, 16'hffff, 16'h0000},
                 {4'h0, 16'h0000, 16'h8000}};
        {sys_rst_in, nmi_in, pins, wr, rd, slow} = 9'h1f8;
        addr  = 4'h0;
        wdata = 16'h0000;
        repeat (10) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        rd_reg(4'h0, 16'h8000);
        foreach (rows[i]) begin
            wr_reg(rows[i][35:32], rows[i][31:16]);
            rd_reg(rows[i][35:32], rows[i][15:0]);
        end
        @(posedge clk_sys_in);
        nmi_in <= 1'b0;
        wait_ack();
        eq(16'(seen), 16'h004f);
        rd_reg(4'h0, 16'h0000);
        @(posedge clk_sys_in);
        nmi_in <= 1'b1;
        no_ack(10);
        @(posedge clk_sys_in);
        nmi_in <= 1'b0;
        @(posedge clk_sys_in);
        nmi_in <= 1'b1;
        no_ack(10);
        @(posedge clk_sys_in);
        slow <= 1'b1;
        pins <= 4'h3;
        wait_ack();
        eq(16'(seen), 16'h0034);
        wait_ack();
        @(posedge clk_sys_in);
        pins <= 4'hf;
        repeat (12) @(posedge clk_sys_in);
        slow <= 1'b0;
        wr_reg(4'h1, 16'h1b00);
        wr_reg(4'h0, 16'h00f0);
        pins <= 4'h0;
        repeat (4) @(posedge clk_sys_in);
        pins <= 4'hf;
        repeat (12) @(posedge clk_sys_in);
        wr_reg(4'h2, 16'h0000);
        rd_reg(4'h2, 16'h00e0);
        wr_reg(4'h2, 16'h0000);
        rd_reg(4'h2, 16'h0000);
        wr_reg(4'h0, 16'h0100);
        nmi_in <= 1'b0;
        no_ack(10);
        @(posedge clk_sys_in);
        nmi_in <= 1'b1;
        wait_ack();
        eq(16'(seen), 16'h004f);
        // A level request stands, then a reset lands in the middle of it.
        @(posedge clk_sys_in);
        slow <= 1'b1;
        pins <= 4'he;
        repeat (5) @(posedge clk_sys_in);
        #1;
        eq(16'({req, nmi, notify_n, lvl, src}), 16'h0208);
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b1;
        pins       <= 4'hf;
        repeat (2) @(posedge clk_sys_in);
        #1;
        eq(16'({req, nmi, notify_n, lvl, src}), 16'h0080);
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        slow       <= 1'b0;
        rd_reg(4'h0, 16'h8000);
        rd_reg(4'h1, 16'h0000);
        rd_reg(4'h3, 16'h0000);
        test_done();
    end
endmodule // external_interrupt_sense_control_test
